/* shared/srw_defs.svh */
/*
 * Timing and build-option constants for the supervisor reset watchdog.
 * Assumes a 25 MHz timebase clock; times are in nanoseconds unless noted.
 */
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

`define SRW_CLK_PERIOD_NS 40
`define SRW_NS_PER_PF_X100 267000
`define SRW_RESET_CAP_PF 1500
`define SRW_WDOG_CAP_PF 1500
`define SRW_EXT_MULT 500
`define SRW_KEEPALIVE_PCT 94
`define SRW_CNT_W 40
`define SRW_ACTIVE_HIGH_DEF 1'b0
`define SRW_OPEN_DRAIN_DEF 1'b1

`endif

/* shared/srw_pkg.sv */
/*
 * Types for the supervisor reset watchdog.
 * Assumes srw_defs.svh is on the include path.
 */
`include "srw_defs.svh"

package srw_pkg;

    typedef enum logic [1:0] {
        SRW_RUN,
        SRW_LOW_VOLT,
        SRW_HOLD
    } srw_state_t;

    typedef struct packed {
        logic mode_sel;
        logic kick_in;
        logic kick_driven;
    } srw_host_in_t;

    typedef struct packed {
        logic reset_out;
        logic reset_oe_n;
        logic reset_asserted;
    } srw_reset_pin_t;

endpackage : srw_pkg

/* hdl/srw_sync.sv */
/*
 * Two-flop synchroniser for a vector of levels.
 * Assumes the inputs are levels with no timing relation to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module srw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= i_d;
            q_reg <= meta_reg;
        end
    end

    assign o_q = q_reg;

endmodule : srw_sync

`default_nettype wire

/* hdl/srw_edge.sv */
/*
 * Edge detector on synchronised levels: pulses on any change.
 * Assumes its input is already synchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module srw_edge #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_change
);

    logic [WIDTH-1:0] prev_reg;
    logic primed_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_reg <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg <= i_level;
            primed_reg <= 1'b1;
        end
    end

    // No change is reported on the first sample after reset
    assign o_change = primed_reg ? (i_level ^ prev_reg) : '0;

endmodule : srw_edge

`default_nettype wire

/* hdl/srw_supervisor.sv */
/*
 * Supervisor: brown-out reset with hold time and a kick-serviced watchdog.
 * Assumes a free-running 25 MHz clock, a digital under-voltage flag from an
 * outside comparator, and host pins given as levels (kick, mode, kick driven).
 */
`timescale 1ns/1ns
`default_nettype none

`include "srw_defs.svh"

// What this block does
// - Reset asserts four clocks after monitored voltage drops below trip point, held while below.
// - After voltage recovers, reset holds one full hold period then releases.
// - Hold period equals 2.67 us per pF of reset capacitor.
// - Basic watchdog timeout equals 2.67 us per pF of watchdog capacitor.
// - Watchdog capacitor node grounded disables the watchdog entirely.
// - Mode low uses basic timeout; mode high uses multiplied extended timeout.
// - Any mode-select level change clears the watchdog counter, which restarts.
// - Any kick or mode edge clears the watchdog counter to zero.
// - Counter held clear during reset, counts from zero after release.
// - Counter reaching timeout asserts reset for one hold period.
// - In extended mode an undriven kick input disables watchdog resets.
// - Reset output built active-low or active-high, open-drain or push-pull.
// - Extended timeout is basic timeout multiplied by 500.
// - Undriven kick in extended mode is pulsed internally at 94 percent.
// - In normal mode an undriven kick does not disable the watchdog.
module srw_supervisor #(
    parameter int CNT_W = `SRW_CNT_W,
    parameter logic [CNT_W-1:0] RESET_HOLD_CYCLES =
        CNT_W'((64'(`SRW_RESET_CAP_PF) * `SRW_NS_PER_PF_X100 / 100) / `SRW_CLK_PERIOD_NS),
    parameter logic [CNT_W-1:0] WDOG_BASE_CYCLES =
        CNT_W'((64'(`SRW_WDOG_CAP_PF) * `SRW_NS_PER_PF_X100 / 100) / `SRW_CLK_PERIOD_NS),
    parameter logic [CNT_W-1:0] EXT_MULT = CNT_W'(`SRW_EXT_MULT),
    parameter logic ACTIVE_HIGH = `SRW_ACTIVE_HIGH_DEF,
    parameter logic OPEN_DRAIN = `SRW_OPEN_DRAIN_DEF
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_under_voltage,
    input wire logic i_wdog_cap_grounded,
    input wire srw_pkg::srw_host_in_t i_host,
    output srw_pkg::srw_reset_pin_t o_reset,
    output logic [CNT_W-1:0] o_wdog_count
);
    import srw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning

    localparam int NSYNC = 5;
    localparam logic [CNT_W-1:0] PCT_FULL = CNT_W'(100);
    localparam logic [CNT_W-1:0] PCT_KEEP = CNT_W'(`SRW_KEEPALIVE_PCT);

    logic [NSYNC-1:0] raw_vec;
    logic [NSYNC-1:0] sync_vec;
    logic [1:0] change_vec;
    logic under_v;
    logic cap_gnd;
    logic mode_s;
    logic kick_s;
    logic driven_s;
    logic kick_eff;
    logic kick_edge;
    logic mode_edge;

    assign raw_vec = {i_under_voltage, i_wdog_cap_grounded, i_host.mode_sel,
                      i_host.kick_in, i_host.kick_driven};

    srw_sync #(.WIDTH(NSYNC)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_d(raw_vec),
        .o_q(sync_vec)
    );

    assign under_v = sync_vec[4];
    assign cap_gnd = sync_vec[3];
    assign mode_s = sync_vec[2];
    assign kick_s = sync_vec[1];
    assign driven_s = sync_vec[0];

    ////////////////////////////////////////////////////////////////////////////
    // Kick line: undriven in extended mode idles low, pulsed high near timeout

    logic keep_pulse_reg;
    logic keep_pulse_next;

    // In normal mode an undriven pin is just read as its level
    assign kick_eff = (mode_s && !driven_s) ? keep_pulse_reg : kick_s;

    srw_edge #(.WIDTH(2)) u_edge (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_level({mode_s, kick_eff}),
        .o_change(change_vec)
    );

    assign mode_edge = change_vec[1];
    assign kick_edge = change_vec[0];

    ////////////////////////////////////////////////////////////////////////////
    // Timeout selection

    function automatic logic [CNT_W-1:0] sel_timeout(input logic ext);
        sel_timeout = ext ? CNT_W'(WDOG_BASE_CYCLES * EXT_MULT) : WDOG_BASE_CYCLES;
    endfunction : sel_timeout

    logic [CNT_W-1:0] timeout_cyc;
    logic [CNT_W-1:0] keep_cyc;
    logic wdog_off;

    assign timeout_cyc = sel_timeout(mode_s);
    assign keep_cyc = CNT_W'((timeout_cyc * PCT_KEEP) / PCT_FULL);
    assign wdog_off = cap_gnd;

    ////////////////////////////////////////////////////////////////////////////
    // Supervisor state

    srw_state_t state_reg;
    srw_state_t state_next;
    logic [CNT_W-1:0] hold_cnt_reg;
    logic [CNT_W-1:0] hold_cnt_next;
    logic [CNT_W-1:0] wd_cnt_reg;
    logic [CNT_W-1:0] wd_cnt_next;
    logic reset_on;

    assign reset_on = (state_reg != SRW_RUN);

    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        wd_cnt_next = wd_cnt_reg;
        keep_pulse_next = 1'b0;
        case (state_reg)
            SRW_RUN: begin
                if (under_v) begin
                    state_next = SRW_LOW_VOLT;
                    wd_cnt_next = '0;
                end else if (mode_edge || kick_edge) begin
                    wd_cnt_next = '0;
                end else if (wdog_off) begin
                    wd_cnt_next = '0;
                end else if (wd_cnt_reg + CNT_W'(1) >= timeout_cyc) begin
                    // Not reached when the internal pulse services it
                    state_next = SRW_HOLD;
                    hold_cnt_next = '0;
                    wd_cnt_next = '0;
                end else begin
                    wd_cnt_next = wd_cnt_reg + CNT_W'(1);
                    // Internal high pulse at the keep-alive point
                    keep_pulse_next = mode_s && !driven_s && (wd_cnt_next >= keep_cyc);
                end
            end
            SRW_LOW_VOLT: begin
                wd_cnt_next = '0;
                hold_cnt_next = '0;
                if (!under_v) begin
                    state_next = SRW_HOLD;
                end
            end
            SRW_HOLD: begin
                wd_cnt_next = '0;
                if (under_v) begin
                    state_next = SRW_LOW_VOLT;
                end else if (hold_cnt_reg + CNT_W'(1) >= RESET_HOLD_CYCLES) begin
                    state_next = SRW_RUN;
                    hold_cnt_next = '0;
                end else begin
                    hold_cnt_next = hold_cnt_reg + CNT_W'(1);
                end
            end
            default: begin
                state_next = SRW_LOW_VOLT;
                hold_cnt_next = '0;
                wd_cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= SRW_LOW_VOLT;
            hold_cnt_reg <= '0;
            wd_cnt_reg <= '0;
            keep_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            keep_pulse_reg <= keep_pulse_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pin

    srw_reset_pin_t pin_reg;
    srw_reset_pin_t pin_next;
    logic level;

    always_comb begin
        level = ACTIVE_HIGH ? reset_on : !reset_on;
        pin_next.reset_asserted = reset_on;
        if (OPEN_DRAIN) begin
            // Open drain only pulls toward the asserted level
            pin_next.reset_out = ACTIVE_HIGH ? 1'b1 : 1'b0;
            pin_next.reset_oe_n = !reset_on;
        end else begin
            pin_next.reset_out = level;
            pin_next.reset_oe_n = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_reg <= '{reset_out: (ACTIVE_HIGH ? 1'b1 : 1'b0), reset_oe_n: 1'b0, reset_asserted: 1'b1};
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign o_reset = pin_reg;
    assign o_wdog_count = wd_cnt_reg;

endmodule : srw_supervisor

`default_nettype wire

/* verif/srw_supervisor_assertions.sv */
/* Checker for the supervisor reset watchdog; sees only the top module ports.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module srw_supervisor_assertions #(
    parameter int CNT_W = 40,
    parameter logic [CNT_W-1:0] RESET_HOLD_CYCLES = 20,
    parameter logic [CNT_W-1:0] WDOG_BASE_CYCLES = 50,
    parameter logic ACTIVE_HIGH = 1'b0,
    parameter logic OPEN_DRAIN = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_under_voltage,
    input wire logic i_wdog_cap_grounded,
    input wire srw_pkg::srw_host_in_t i_host,
    input wire srw_pkg::srw_reset_pin_t o_reset,
    input wire logic [CNT_W-1:0] o_wdog_count
);
    import srw_pkg::*;
    localparam int HMIN = int'(RESET_HOLD_CYCLES) + 1;
    localparam int HMAX = HMIN + 5;
    logic [CNT_W-1:0] run_reg;
    logic [CNT_W-1:0] run_next;
    logic asr;
    assign asr = o_reset.reset_asserted;
    always_comb run_next = asr ? run_reg + 1'b1 : '0;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) run_reg <= '0;
        else run_reg <= run_next;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_uv_assert: assert property ($rose(i_under_voltage) ##1 i_under_voltage[*4] |-> asr)
        else $error("reset missing on low voltage");
    a_hold_len: assert property ($fell(asr) |-> run_reg >= RESET_HOLD_CYCLES)
        else $error("reset pulse too short");
    a_uv_release: assert property ($fell(i_under_voltage) |-> ##[HMIN:HMAX] !asr)
        else $error("reset not released after hold");
    a_cap_off: assert property (i_wdog_cap_grounded[*4] |-> o_wdog_count == '0)
        else $error("counter runs with cap grounded");
    a_kick_clear: assert property ($changed(i_host.kick_in) && i_host.kick_driven ##1 i_host.kick_driven[*2]
        |-> ##[1:2] o_wdog_count == '0)
        else $error("kick did not clear counter");
    a_mode_clear: assert property ($changed(i_host.mode_sel) |-> ##[3:4] o_wdog_count == '0)
        else $error("mode change did not clear counter");
    a_wdog_expire: assert property ((!i_host.mode_sel)[*4] ##0 (o_wdog_count == WDOG_BASE_CYCLES - 1'b1)
        |-> ##[2:3] asr)
        else $error("no reset on watchdog expiry");
    a_pin_form: assert property (OPEN_DRAIN ? (o_reset.reset_oe_n == !asr && o_reset.reset_out == ACTIVE_HIGH)
        : (!o_reset.reset_oe_n && o_reset.reset_out == (asr ~^ ACTIVE_HIGH)))
        else $error("reset pin form wrong");
    c_uv: cover property ($fell(i_under_voltage));
    c_pulse: cover property ($fell(asr));
    c_keep: cover property (i_host.mode_sel && !i_host.kick_driven);
endmodule : srw_supervisor_assertions
bind srw_supervisor srw_supervisor_assertions #(.CNT_W(CNT_W), .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
    .WDOG_BASE_CYCLES(WDOG_BASE_CYCLES), .ACTIVE_HIGH(ACTIVE_HIGH), .OPEN_DRAIN(OPEN_DRAIN))
    srw_supervisor_assertions_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_under_voltage(i_under_voltage),
    .i_wdog_cap_grounded(i_wdog_cap_grounded), .i_host(i_host), .o_reset(o_reset), .o_wdog_count(o_wdog_count));
`default_nettype wire

/* verif/srw_host_model.sv */
/* Host model: toggles the kick line every i_period cycles (0 = never).
   Assumes the kick pin idles low when released. */
`timescale 1ns/1ns
`default_nettype none
module srw_host_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_mode,
    input wire logic i_drive,
    input wire logic [15:0] i_period,
    output srw_pkg::srw_host_in_t o_host
);
    import srw_pkg::*;
    logic [15:0] cnt_reg;
    logic kick_reg;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 16'h0;
            kick_reg <= 1'b0;
        end else if (i_period != 16'h0 && cnt_reg >= i_period - 16'h1) begin
            cnt_reg <= 16'h0;
            kick_reg <= ~kick_reg;
        end else begin
            cnt_reg <= cnt_reg + 16'h1;
        end
    end
    assign o_host = '{mode_sel: i_mode, kick_in: i_drive & kick_reg, kick_driven: i_drive};
endmodule : srw_host_model
`default_nettype wire

/* verif/tb.sv */
/* Bench for the supervisor reset watchdog with the host model.
   Assumes short hold and timeout counts set below. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %0d got %0d", s, e, g); end end
module tb;
    import srw_pkg::*;
    localparam int HOLD = 20;
    localparam int BASE = 50;
    typedef struct {logic m; logic d; logic g; logic [15:0] p; int n; logic e;} srw_row_t;
    srw_row_t rows [6] = '{'{0, 1, 0, 20, 400, 0}, '{0, 1, 0, 0, 400, 1}, '{1, 1, 0, 100, 600, 0},
        '{0, 1, 1, 0, 400, 0}, '{1, 0, 0, 0, 1000, 0}, '{0, 0, 0, 0, 400, 1}};
    logic i_clk = 1'b0;
    logic rst_n = 1'b0;
    logic uv = 1'b0;
    logic gnd = 1'b0;
    logic mode = 1'b0;
    logic drive = 1'b1;
    logic [15:0] period = 16'h0;
    srw_host_in_t host;
    srw_reset_pin_t pin;
    logic [39:0] cnt;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int rises = 0;
    int run = 0;
    int idle = 0;
    int width = 0;
    int gap = 0;
    int r0;
    int n;
    always #20 i_clk = ~i_clk;
    srw_supervisor #(.RESET_HOLD_CYCLES(40'(HOLD)), .WDOG_BASE_CYCLES(40'(BASE)), .EXT_MULT(40'h4)) srw_supervisor_inst (
        .i_clk(i_clk), .i_reset_n(rst_n), .i_under_voltage(uv), .i_wdog_cap_grounded(gnd),
        .i_host(host), .o_reset(pin), .o_wdog_count(cnt));
    srw_host_model srw_host_model_inst (.i_clk(i_clk), .i_reset_n(rst_n), .i_mode(mode), .i_drive(drive),
        .i_period(period), .o_host(host));
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
    endtask : tick
    ////////////////////////////////////////////////////////////////
    always @(negedge i_clk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            test_done();
        end
        if (pin.reset_asserted === 1'b1) begin
            if (run == 0) begin
                rises++;
                gap = idle;
            end
            run++;
            idle = 0;
        end else begin
            if (run != 0) width = run;
            run = 0;
            idle++;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            mode <= rows[i].m;
            drive <= rows[i].d;
            gnd <= rows[i].g;
            period <= rows[i].p;
            tick(HOLD + 10);
            r0 = rises;
            tick(rows[i].n);
            `CHK("row_reset", rows[i].e, rises != r0)
            $display("row %0d done", i);
        end
        drive <= 1'b1;
        tick(200);
        `CHK("width", HOLD, width)
        `CHK("gap", 1'b1, gap >= BASE && gap <= BASE + 3)
        mode <= 1'b1;
        tick(520);
        `CHK("ext_gap", 1'b1, gap >= BASE * 4 && gap <= BASE * 4 + 3)
        for (int k = 0; k < 12; k++) begin
            mode <= ~mode;
            tick(30);
            if (k == 1) r0 = rises;
        end
        `CHK("mode_toggle", r0, rises)
        $display("timing done");
        period <= 16'h14;
        tick(40);
        uv <= 1'b1;
        tick(3);
        @(negedge i_clk);
        `CHK("uv_early", 1'b0, pin.reset_asserted)
        tick(1);
        @(negedge i_clk);
        `CHK("uv_assert", 1'b1, pin.reset_asserted)
        `CHK("oe_n_low", 1'b0, pin.reset_oe_n)
        tick(40);
        @(negedge i_clk);
        `CHK("uv_held", 1'b1, pin.reset_asserted)
        `CHK("cnt_clear", 40'h0, cnt)
        tick(1);
        uv <= 1'b0;
        n = 0;
        do begin
            tick(1);
            @(negedge i_clk);
            n++;
        end while (pin.reset_asserted === 1'b1 && n < 100);
        `CHK("uv_hold", 1'b1, n >= HOLD + 1 && n <= HOLD + 6)
        `CHK("oe_n_high", 1'b1, pin.reset_oe_n)
        $display("voltage done");
        tick(1);
        rst_n <= 1'b0;
        tick(10);
        @(negedge i_clk);
        `CHK("rst_assert", 1'b1, pin.reset_asserted)
        `CHK("rst_cnt", 40'h0, cnt)
        tick(1);
        rst_n <= 1'b1;
        tick(HOLD + 10);
        $display("reset done");
        test_done();
    end
endmodule : tb
`default_nettype wire
